// ---- hdl/adc_result_and_trigger_control.v ----
// Purpose: register file, trigger logic and result handling around a 10-bit converter
// Assumes: analog engine delivers conversion_result with a one-cycle sample strobe
// Notes: APB slave, zero wait states, pslverr on unmapped addresses
`timescale 1ns/1ps
`include "adc_ctrl_defines.vh"

module adc_result_and_trigger_control
(
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire global_irq_enable,
    input wire vector_ack,
    input wire comparator_flag,
    input wire ext_irq0_flag,
    input wire timer0_compare_flag,
    input wire timer0_overflow_flag,
    input wire timer1_compare_b_flag,
    input wire timer1_overflow_flag,
    input wire timer1_capture_flag,
    input wire sample_valid,
    input wire [9:0] conversion_result,
    input wire [7:0] analog_pin_level,
    output reg [7:0] port_pin_input,
    output reg [7:0] pin_input_disable_bits,
    output reg [4:0] channel_select_bits,
    output reg comparator_mux_enable,
    output reg conversion_active,
    output reg converter_tick,
    output reg conv_done_irq,
    output reg irq
);

// ----------------------------------------------------------------
// register state
// ----------------------------------------------------------------
reg converter_enable;
reg start_busy;
reg auto_trigger_enable;
reg conv_done_flag;
reg conv_done_irq_enable;
reg [2:0] clock_divider_select;
reg left_adjust_select;
reg [2:0] trigger_source_select;
reg [9:0] held_result;
reg read_lock;
reg first_conv;
reg [4:0] conv_count;
reg trig_prev;
reg [1:0] irq_status;
reg [1:0] irq_mask;
wire tick;
wire [7:0] result_low_byte;
wire [7:0] result_high_byte;
wire setup;
wire access;
wire wr;
wire rd;
wire trig_level;
wire trig_rise;
wire conv_end;
wire done_event;
wire start_req;
reg [31:0] next_rdata;
reg next_slverr;

assign setup = psel & ~penable;
assign access = psel & penable & clk_en;
assign wr = access & pwrite;
assign rd = access & ~pwrite;

// ----------------------------------------------------------------
// prescaler
// ----------------------------------------------------------------
clock_prescaler u_prescaler
(
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .run(converter_enable),
    .clock_divider_select(clock_divider_select),
    .tick(tick)
);

// ----------------------------------------------------------------
// trigger selection
// ----------------------------------------------------------------
// selected flag; free running follows the done flag
function select_flag;
    input [2:0] sel;
    input [7:0] flags;
    begin
        select_flag = flags[sel];
    end
endfunction

assign trig_level = select_flag(trigger_source_select,
    {timer1_capture_flag, timer1_overflow_flag, timer1_compare_b_flag,
     timer0_overflow_flag, timer0_compare_flag, ext_irq0_flag,
     comparator_flag, conv_done_flag});

// edge is taken on the muxed level so a source switch counts too
assign trig_rise = trig_level & ~trig_prev & (trigger_source_select != 3'h0);

// free running restarts at each conversion end, even while the result is locked
assign start_req = auto_trigger_enable & converter_enable &
    ((trig_rise & ~start_busy) | ((trigger_source_select == 3'h0) & conv_end));

// track previous trigger level, a switch to free running leaves no edge
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        trig_prev <= 1'b0;
    else if (clk_en)
        trig_prev <= trig_level;
end

// ----------------------------------------------------------------
// conversion sequencing
// ----------------------------------------------------------------
assign conv_end = start_busy & tick & (conv_count == 5'd1);
assign done_event = conv_end & sample_valid & ~read_lock &
    ~(psel & ~pwrite & (paddr == `OFS_RESULT_LOW));

// count converter clock cycles of a running conversion
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        start_busy <= 1'b0;
        conv_count <= 5'd0;
        first_conv <= 1'b1;
    end
    else if (clk_en)
    begin
        if (!converter_enable)
        begin
            start_busy <= 1'b0;
            conv_count <= 5'd0;
            first_conv <= 1'b1;
            if (wr && paddr == `OFS_CONTROL_A && pwdata[`CA_ENABLE] && pwdata[`CA_START])
            begin
                start_busy <= 1'b1;
                conv_count <= `CONV_FIRST;
                first_conv <= 1'b0;
            end
        end
        else if (!start_busy && (start_req ||
                 (wr && paddr == `OFS_CONTROL_A && pwdata[`CA_START])))
        begin
            start_busy <= 1'b1;
            conv_count <= first_conv ? `CONV_FIRST : `CONV_CYCLES;
            first_conv <= 1'b0;
        end
        else if (start_busy && tick)
        begin
            conv_count <= start_req ? `CONV_CYCLES : conv_count - 5'd1;
            if (conv_count == 5'd1)
                start_busy <= start_req;
        end
    end
end

// ----------------------------------------------------------------
// result bytes and read lock
// ----------------------------------------------------------------
// raw converter bits pass through; differential results arrive signed
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        held_result <= 10'h000;
    else if (clk_en && done_event)
        held_result <= conversion_result;
end

// lock set by low byte read, released by high byte read
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        read_lock <= 1'b0;
    else if (rd && paddr == `OFS_RESULT_HIGH)
        read_lock <= 1'b0;
    else if (rd && paddr == `OFS_RESULT_LOW)
        read_lock <= 1'b1;
end

// adjustment applies at once to the held value
assign result_high_byte = left_adjust_select ? held_result[9:2] :
    {6'h00, held_result[9:8]};
assign result_low_byte = left_adjust_select ? {held_result[1:0], 6'h00} :
    held_result[7:0];

// ----------------------------------------------------------------
// control registers
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        converter_enable <= 1'b0;
        auto_trigger_enable <= 1'b0;
        conv_done_irq_enable <= 1'b0;
        clock_divider_select <= 3'h0;
        left_adjust_select <= 1'b0;
        channel_select_bits <= 5'h00;
        trigger_source_select <= 3'h0;
        comparator_mux_enable <= 1'b0;
        pin_input_disable_bits <= `RST_BYTE;
        irq_mask <= 2'h0;
    end
    else if (wr)
    begin
        case (paddr)
            `OFS_CONTROL_A:
            begin
                converter_enable <= pwdata[`CA_ENABLE];
                auto_trigger_enable <= pwdata[`CA_AUTO_TRIG];
                conv_done_irq_enable <= pwdata[`CA_IRQ_ENABLE];
                clock_divider_select <= pwdata[2:0];
            end
            `OFS_CHANNEL_MUX:
            begin
                left_adjust_select <= pwdata[`MUX_LEFT_ADJUST];
                channel_select_bits <= pwdata[4:0];
            end
            `OFS_TRIGGER_SELECT:
            begin
                comparator_mux_enable <= pwdata[6];
                trigger_source_select <= pwdata[2:0]; // reserved bits not stored
            end
            `OFS_PIN_DISABLE: pin_input_disable_bits <= pwdata[7:0];
            `OFS_IRQ_MASK: irq_mask <= pwdata[1:0];
            default: irq_mask <= irq_mask;
        endcase
    end
end

// ----------------------------------------------------------------
// flags and interrupts
// ----------------------------------------------------------------
// done flag: set wins over software write-one and vector clear
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        conv_done_flag <= 1'b0;
    else if (clk_en)
    begin
        if (done_event)
            conv_done_flag <= 1'b1;
        else if (vector_ack || (wr && paddr == `OFS_CONTROL_A && pwdata[`CA_DONE_FLAG]))
            conv_done_flag <= 1'b0;
    end
end

// sticky status: bit0 conversion done, bit1 trigger start; read clears only reported bits
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        irq_status <= 2'h0;
    else if (clk_en)
    begin
        if (rd && paddr == `OFS_IRQ_STATUS)
            irq_status <= (irq_status & ~prdata[1:0]) | {start_req, done_event};
        else
            irq_status <= irq_status | {start_req, done_event};
    end
end

// registered outputs
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        conv_done_irq <= 1'b0;
        irq <= 1'b0;
        conversion_active <= 1'b0;
        converter_tick <= 1'b0;
        port_pin_input <= 8'h00;
    end
    else if (clk_en)
    begin
        conv_done_irq <= conv_done_flag & conv_done_irq_enable & global_irq_enable;
        irq <= |(irq_status & irq_mask);
        conversion_active <= start_busy;
        converter_tick <= tick;
        port_pin_input <= analog_pin_level & ~pin_input_disable_bits;
    end
end

// ----------------------------------------------------------------
// apb read path
// ----------------------------------------------------------------
always @*
begin
    next_rdata = 32'h00000000;
    next_slverr = 1'b0;
    case (paddr)
        `OFS_CONTROL_A: next_rdata = {24'h000000, converter_enable, start_busy,
            auto_trigger_enable, conv_done_flag, conv_done_irq_enable, clock_divider_select};
        `OFS_CHANNEL_MUX: next_rdata = {24'h000000, 2'b00, left_adjust_select,
            channel_select_bits};
        `OFS_RESULT_LOW: next_rdata = {24'h000000, result_low_byte};
        `OFS_RESULT_HIGH: next_rdata = {24'h000000, result_high_byte};
        `OFS_TRIGGER_SELECT: next_rdata = {24'h000000, 1'b0, comparator_mux_enable,
            3'b000, trigger_source_select};
        `OFS_PIN_DISABLE: next_rdata = {24'h000000, pin_input_disable_bits};
        `OFS_IRQ_STATUS: next_rdata = {30'h00000000, irq_status};
        `OFS_IRQ_MASK: next_rdata = {30'h00000000, irq_mask};
        default: next_slverr = 1'b1;
    endcase
end

// answer in the access phase; data latched during setup
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        prdata <= 32'h00000000;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
        pready <= setup;
        pslverr <= setup & next_slverr;
        if (setup && !pwrite)
            prdata <= next_rdata;
    end
end

endmodule // adc_result_and_trigger_control

// ---- inc/adc_ctrl_defines.vh ----
// Purpose: register offsets, field positions, reset values for the converter control block
// Assumes: APB byte addresses, one 32-bit aligned word per register
// Notes: definitions only
`ifndef ADC_CTRL_DEFINES_VH
`define ADC_CTRL_DEFINES_VH

// register byte offsets
`define OFS_CONTROL_A       12'h000
`define OFS_CHANNEL_MUX     12'h004
`define OFS_RESULT_LOW      12'h008
`define OFS_RESULT_HIGH     12'h00c
`define OFS_TRIGGER_SELECT  12'h010
`define OFS_PIN_DISABLE     12'h014
`define OFS_IRQ_STATUS      12'h018
`define OFS_IRQ_MASK        12'h01c

// control a field positions
`define CA_ENABLE       7
`define CA_START        6
`define CA_AUTO_TRIG    5
`define CA_DONE_FLAG    4
`define CA_IRQ_ENABLE   3

// channel mux field positions
`define MUX_LEFT_ADJUST 5
`define MUX_DIFF_BIT    3

// trigger select writable bits (comparator mux enable and source)
`define TRIG_WR_MASK    8'h47

// reset values
`define RST_BYTE        8'h00

// conversion length in converter clock cycles
`define CONV_CYCLES     5'd13
`define CONV_FIRST      5'd25

`endif

// ---- hdl/clock_prescaler.v ----
// Purpose: divides pclk into a converter clock tick by a selectable power of two
// Assumes: enable low holds the divider at zero
// Notes: tick is a one-cycle pulse at the end of each divided period
`timescale 1ns/1ps

module clock_prescaler
(
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire run,
    input wire [2:0] clock_divider_select,
    output reg tick
);

reg [6:0] count;
wire [6:0] limit;

// terminal count per code, codes 0 and 1 both divide by 2
function [6:0] div_limit;
    input [2:0] sel;
    begin
        case (sel)
            3'h0: div_limit = 7'h01;
            3'h1: div_limit = 7'h01;
            3'h2: div_limit = 7'h03;
            3'h3: div_limit = 7'h07;
            3'h4: div_limit = 7'h0f;
            3'h5: div_limit = 7'h1f;
            3'h6: div_limit = 7'h3f;
            default: div_limit = 7'h7f;
        endcase
    end
endfunction

assign limit = div_limit(clock_divider_select);

// free counter, cleared while the converter is off
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        count <= 7'h00;
        tick <= 1'b0;
    end
    else if (clk_en)
    begin
        if (!run)
        begin
            count <= 7'h00;
            tick <= 1'b0;
        end
        else if (count >= limit)
        begin
            count <= 7'h00;
            tick <= 1'b1;
        end
        else
        begin
            count <= count + 7'h01;
            tick <= 1'b0;
        end
    end
end

endmodule // clock_prescaler

// ---- verification/adc_ctrl_properties.sv ----
// Purpose: port properties of the converter control block
// Assumes: apb answer one cycle after setup
// Notes: bound to the design top below
`timescale 1ns/1ps

module adc_ctrl_properties
(
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    input wire global_irq_enable,
    input wire [7:0] analog_pin_level,
    input wire [7:0] port_pin_input,
    input wire [7:0] pin_input_disable_bits,
    input wire comparator_mux_enable,
    input wire converter_tick,
    input wire conv_done_irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // completed write access
    wire wr_acc = psel && penable && pwrite && pready;

    property p_ready_setup;
        psel && !penable && clk_en |=> pready ##1 !pready;
    endproperty
    a_ready_setup: assert property (p_ready_setup) else $error("ready not one cycle");
    property p_ready_only;
        pready |-> psel && penable;
    endproperty
    a_ready_only: assert property (p_ready_only) else $error("ready outside access");
    property p_unmapped;
        psel && !penable && clk_en && paddr > 12'h01c |=> pslverr && pready;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
    property p_pin_input;
        clk_en |=> port_pin_input == ($past(analog_pin_level) & ~$past(pin_input_disable_bits));
    endproperty
    a_pin_input: assert property (p_pin_input) else $error("pin input not gated");
    property p_irq_global;
        conv_done_irq |-> $past(global_irq_enable);
    endproperty
    a_irq_global: assert property (p_irq_global) else $error("irq without global");
    property p_tick_gap;
        converter_tick |=> !converter_tick;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("tick faster than 2");
    property p_disable_write;
        wr_acc && paddr == 12'h014 |=> pin_input_disable_bits == $past(pwdata[7:0]);
    endproperty
    a_disable_write: assert property (p_disable_write) else $error("disable not written");
    property p_cmux_write;
        wr_acc && paddr == 12'h010 |=> comparator_mux_enable == $past(pwdata[6]);
    endproperty
    a_cmux_write: assert property (p_cmux_write) else $error("trigger reg not written");

    // main scenarios reached
    c_tick: cover property (converter_tick);
    c_done: cover property (conv_done_irq);
    c_err: cover property (pslverr);
endmodule // adc_ctrl_properties

bind adc_result_and_trigger_control adc_ctrl_properties u_props (.pclk(pclk),
    .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .global_irq_enable(global_irq_enable), .analog_pin_level(analog_pin_level),
    .port_pin_input(port_pin_input), .pin_input_disable_bits(pin_input_disable_bits),
    .comparator_mux_enable(comparator_mux_enable), .converter_tick(converter_tick),
    .conv_done_irq(conv_done_irq));

// ---- verification/testbench.sv ----
// Purpose: self-checking bench for the converter control block
// Assumes: zero-wait apb slave, sample_valid held high
// Notes: random values from a fixed seed
`timescale 1ns/1ps

module testbench;
    reg pclk, presetn, psel, penable, pwrite, global_irq_enable, vector_ack, perr;
    reg [11:0] paddr;
    reg [31:0] pwdata, rdat;
    reg [9:0] cr, res, res2;
    reg [7:1] tf;
    reg [7:0] lvl;
    integer seed, n_fail, total_checks, i, n;
    wire [31:0] prdata;
    wire pready, pslverr, conversion_active, converter_tick, conv_done_irq, irq;
    wire [7:0] port_pin_input, pin_input_disable_bits;
    wire [4:0] channel_select_bits;
    wire [2:0] mon = {conversion_active, converter_tick, conv_done_irq};

    adc_result_and_trigger_control uut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .global_irq_enable(global_irq_enable), .vector_ack(vector_ack),
        .comparator_flag(tf[1]), .ext_irq0_flag(tf[2]), .timer0_compare_flag(tf[3]),
        .timer0_overflow_flag(tf[4]), .timer1_compare_b_flag(tf[5]),
        .timer1_overflow_flag(tf[6]), .timer1_capture_flag(tf[7]), .sample_valid(1'b1),
        .conversion_result(cr), .analog_pin_level(lvl), .port_pin_input(port_pin_input),
        .pin_input_disable_bits(pin_input_disable_bits),
        .channel_select_bits(channel_select_bits),
        .comparator_mux_enable(), .conversion_active(conversion_active),
        .converter_tick(converter_tick), .conv_done_irq(conv_done_irq), .irq(irq));

    // 200 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task chk(input [31:0] got, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp)
            begin
                n_fail = n_fail + 1;
                $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    task results;
        begin
            $display("checks %0d mismatches %0d", total_checks, n_fail);
            if (n_fail == 0 && total_checks > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask

    // bounded wait for one monitored output to reach a level
    task wait_for(input integer b, input v, input integer lim);
        integer k;
        begin
            k = 0;
            while (mon[b] !== v && k < lim)
            begin
                @(posedge pclk);
                k = k + 1;
            end
            if (k >= lim)
            begin
                n_fail = n_fail + 1;
                $display("mismatch at %0t: wait ran out", $time);
                results;
            end
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task apb(input [11:0] a, input w, input [31:0] d);
        integer k;
        begin
            psel <= 1'b1;
            paddr <= a;
            pwrite <= w;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            k = 0;
            while (pready !== 1'b1 && k < 20)
            begin
                @(posedge pclk);
                k = k + 1;
            end
            if (k >= 20)
            begin
                n_fail = n_fail + 1;
                $display("mismatch at %0t: no ready", $time);
                results;
            end
            rdat = prdata;
            perr = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask

    function integer divf(input [2:0] c);
        divf = (c < 2) ? 2 : (1 << c);
    endfunction

    // main sequence
    initial
    begin
        seed = 96740;
        n_fail = 0;
        total_checks = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, vector_ack, perr} = 5'h0;
        global_irq_enable = 1'b1;
        paddr = 12'h000;
        pwdata = 32'h0;
        {cr, tf, lvl} = 25'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (i = 8; i <= 20; i = i + 4)
        begin
            apb(i, 1'b0, 32'h0);
            chk(rdat, 32'h0);
        end
        apb(12'h020, 1'b0, 32'h0);
        chk(perr, 1'b1);
        for (i = 0; i < 8; i = i + 1)
        begin
            n = (i == 7) ? 32'hffff : $random(seed);
            lvl <= n[7:0];
            apb(12'h014, 1'b1, {24'h0, n[15:8]});
            apb(12'h014, 1'b0, 32'h0);
            chk(rdat, {24'h0, n[15:8]});
            chk(port_pin_input, n[7:0] & ~n[15:8]);
        end
        apb(12'h01c, 1'b1, 32'h1);
        res = $random(seed);
        cr <= res;
        apb(12'h008, 1'b1, 32'hff);
        apb(12'h000, 1'b1, 32'hc8);
        wait_for(0, 1'b1, 600);
        chk(irq, 1'b1);
        apb(12'h008, 1'b0, 32'h0);
        chk(rdat, res[7:0]);
        apb(12'h00c, 1'b0, 32'h0);
        chk(rdat, res[9:8]);
        apb(12'h004, 1'b1, 32'h35);
        chk(channel_select_bits, 5'h15);
        apb(12'h008, 1'b0, 32'h0);
        chk(rdat, {res[1:0], 6'h0});
        apb(12'h00c, 1'b0, 32'h0);
        chk(rdat, res[9:2]);
        apb(12'h004, 1'b1, 32'h0);
        apb(12'h018, 1'b0, 32'h0);
        chk(rdat[0], 1'b1);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        global_irq_enable <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(conv_done_irq, 1'b0);
        global_irq_enable <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(conv_done_irq, 1'b1);
        vector_ack <= 1'b1;
        @(posedge pclk);
        vector_ack <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(conv_done_irq, 1'b0);
        // low byte read locks out the next result
        apb(12'h008, 1'b0, 32'h0);
        res2 = $random(seed);
        cr <= res2;
        apb(12'h000, 1'b1, 32'hc8);
        wait_for(2, 1'b1, 40);
        wait_for(2, 1'b0, 600);
        apb(12'h00c, 1'b0, 32'h0);
        chk(rdat, res[9:8]);
        apb(12'h008, 1'b0, 32'h0);
        chk(rdat, res[7:0]);
        apb(12'h00c, 1'b0, 32'h0);
        apb(12'h000, 1'b1, 32'hd8);
        wait_for(0, 1'b1, 600);
        apb(12'h008, 1'b0, 32'h0);
        chk(rdat, res2[7:0]);
        apb(12'h00c, 1'b0, 32'h0);
        for (i = 0; i < 8; i = i + 1)
        begin
            apb(12'h000, 1'b1, 32'h80 | i);
            wait_for(1, 1'b1, 300);
            n = 1;
            @(posedge pclk);
            while (converter_tick !== 1'b1 && n < 300)
            begin
                @(posedge pclk);
                n = n + 1;
            end
            chk(n, divf(i));
        end
        // trigger sources 1 to 7 in turn; status bit1 records the triggered start
        apb(12'h000, 1'b1, 32'ha0);
        for (i = 1; i < 8; i = i + 1)
        begin
            apb(12'h010, 1'b1, i);
            tf[i] <= 1'b1;
            wait_for(2, 1'b1, 40);
            wait_for(2, 1'b0, 600);
            tf[i] <= 1'b0;
            apb(12'h018, 1'b0, 32'h0);
            chk(rdat[1:0], 2'h3);
        end
        tf[3] <= 1'b1;
        apb(12'h010, 1'b1, 32'h3);
        wait_for(2, 1'b1, 40);
        wait_for(2, 1'b0, 600);
        apb(12'h018, 1'b0, 32'h0);
        chk(rdat[1], 1'b1);
        // short waits so a wrongly started conversion is still running
        apb(12'h000, 1'b1, 32'h80);
        apb(12'h010, 1'b1, 32'h2);
        tf <= 7'h02;
        repeat (5) @(posedge pclk);
        chk(conversion_active, 1'b0);
        tf <= 7'h0;
        apb(12'h000, 1'b1, 32'ha0);
        apb(12'h010, 1'b1, 32'h0);
        repeat (5) @(posedge pclk);
        chk(conversion_active, 1'b0);
        // free running: one software start, then restarts at every end
        apb(12'h018, 1'b0, 32'h0);
        apb(12'h000, 1'b1, 32'he0);
        repeat (40) @(posedge pclk);
        apb(12'h018, 1'b0, 32'h0);
        chk(rdat[1], 1'b1);
        chk(conversion_active, 1'b1);
        results;
    end
endmodule // testbench
